// ---- logic/omb_mailbox.sv ----
// One-slot mailbox passing a command word and a payload pointer from a
// sending processor to a receiving processor over two slave ports.
// Assumes one system clock and a reset released in step with it.
//
// Contract
// - Command at word 0, pointer at word 1.
// - Sender command write sets pending, raises interrupt.
// - Receiver command read consumes message, clears status.
// - Sender port stalls while message is pending.
// - Pending interrupt is a level until retrieval.
// - Interrupts come from status bits and masks.
// - Whole mailbox runs on one clock.
// - Sender only sets status; receiver only clears.
// - Words writable by sender, read-only to receiver.
// - Message valid without pointer write.
// - Status bit0 pending, bit1 full, reset zero.
// - Mask readable both; each port writes own bit.
// - Mask bit0 pending, bit1 space, 1 enables.
// - Optional level space interrupt to sender.
// - Receiver reads with one fixed wait cycle.
// - Active-low reset, asynchronous assert, synchronous release.
`timescale 1ns/1ps
module omb_mailbox #(
  parameter int DATA_W = 32,
  parameter bit ARRIVAL_IRQ_EN = 1'b1,
  parameter bit SPACE_IRQ_EN = 1'b0
)
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [omb_pkg::OMB_ADDR_W-1:0] snd_addr_i,
  input wire logic snd_read_i,
  input wire logic snd_write_i,
  input wire logic [DATA_W-1:0] snd_wdata_i,
  output logic [DATA_W-1:0] snd_rdata_o,
  output logic snd_waitreq_o,
  input wire logic [omb_pkg::OMB_ADDR_W-1:0] rcv_addr_i,
  input wire logic rcv_read_i,
  input wire logic rcv_write_i,
  input wire logic [DATA_W-1:0] rcv_wdata_i,
  output logic [DATA_W-1:0] rcv_rdata_o,
  output logic irq_msg_o,
  output logic irq_space_o
);
  import omb_pkg::*;

  logic [DATA_W-1:0] cmd_ff;
  logic [DATA_W-1:0] ptr_ff;
  logic pend_ff;
  logic full_ff;
  logic [1:0] mask_ff;
  logic nxt_pend;
  logic nxt_full;
  logic [1:0] nxt_mask;
  logic snd_wr_ok;
  logic snd_cmd_wr;
  logic snd_ptr_wr;
  logic snd_mask_wr;
  logic rcv_mask_wr;
  logic snd_take;
  logic rcv_take;
  logic rcv_consume;
  logic [DATA_W-1:0] stat_word;
  logic [DATA_W-1:0] mask_word;

  // ---------------------------------------------------------------------
  // Port decode
  // ---------------------------------------------------------------------
  // Every clocked process uses the one system clock; crossing to other
  // processor clocks is left to the interconnect.
  always_comb
  begin
    snd_wr_ok = snd_write_i && !snd_waitreq_o;
    snd_cmd_wr = snd_wr_ok && (snd_addr_i == OMB_CMD_OFS);
    snd_ptr_wr = snd_wr_ok && (snd_addr_i == OMB_PTR_OFS);
    snd_mask_wr = snd_wr_ok && (snd_addr_i == OMB_MASK_OFS);
    // The receiver can only ever write its own mask bit.
    rcv_mask_wr = rcv_write_i && (rcv_addr_i == OMB_MASK_OFS);
    rcv_consume = rcv_take && (rcv_addr_i == OMB_CMD_OFS) && pend_ff;
  end

  // ---------------------------------------------------------------------
  // Message state
  // ---------------------------------------------------------------------
  // Pending and full always move together: one slot means a pending
  // message is also a full mailbox. The set term wins over the clear,
  // though the stall makes both in one cycle impossible.
  always_comb
  begin
    nxt_pend = pend_ff;
    nxt_full = full_ff;
    if (snd_cmd_wr)
    begin
      nxt_pend = 1'b1;
      nxt_full = 1'b1;
    end
    else if (rcv_consume)
    begin
      nxt_pend = 1'b0;
      nxt_full = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pend_ff <= OMB_STAT_RST;
      full_ff <= OMB_STAT_RST;
    end
    else
    begin
      pend_ff <= nxt_pend;
      full_ff <= nxt_full;
    end
  end

  // ---------------------------------------------------------------------
  // Command and pointer words
  // ---------------------------------------------------------------------
  // The stall keeps a waiting message intact; the pointer may be loaded
  // ahead of the command while the slot is empty.
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cmd_ff <= OMB_WORD_RST[DATA_W-1:0];
    end
    else if (snd_cmd_wr)
    begin
      cmd_ff <= snd_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ptr_ff <= OMB_WORD_RST[DATA_W-1:0];
    end
    else if (snd_ptr_wr)
    begin
      ptr_ff <= snd_wdata_i;
    end
  end

  // ---------------------------------------------------------------------
  // Interrupt mask
  // ---------------------------------------------------------------------
  always_comb
  begin
    nxt_mask = mask_ff;
    if (snd_mask_wr)
    begin
      nxt_mask[OMB_MASK_SPACE_BIT] = snd_wdata_i[OMB_MASK_SPACE_BIT];
    end
    if (rcv_mask_wr)
    begin
      nxt_mask[OMB_MASK_PEND_BIT] = rcv_wdata_i[OMB_MASK_PEND_BIT];
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mask_ff <= OMB_MASK_RST;
    end
    else
    begin
      mask_ff <= nxt_mask;
    end
  end

  // ---------------------------------------------------------------------
  // Back-pressure and interrupts
  // ---------------------------------------------------------------------
  // Wait-request is the registered pending state, so it stalls reads as
  // well as writes on the sender port; a sender waiting for room should
  // use the space interrupt rather than polling through this port.
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      snd_waitreq_o <= 1'b0;
    end
    else
    begin
      snd_waitreq_o <= nxt_pend;
    end
  end

  // Both lines are levels formed from the next status and mask values,
  // so they track the status bits with no lag and hold no event state.
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      irq_msg_o <= 1'b0;
      irq_space_o <= 1'b0;
    end
    else
    begin
      irq_msg_o <= ARRIVAL_IRQ_EN && nxt_pend
        && nxt_mask[OMB_MASK_PEND_BIT];
      irq_space_o <= SPACE_IRQ_EN && !nxt_full
        && nxt_mask[OMB_MASK_SPACE_BIT];
    end
  end

  // ---------------------------------------------------------------------
  // Read-back words
  // ---------------------------------------------------------------------
  always_comb
  begin
    stat_word = '0;
    stat_word[OMB_STAT_PEND_BIT] = pend_ff;
    stat_word[OMB_STAT_FULL_BIT] = full_ff;
    mask_word = '0;
    mask_word[1:0] = mask_ff;
  end

  omb_rd_port #(
    .DATA_W(DATA_W)
  ) u_snd_rd (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .read_i(snd_read_i),
    .hold_i(snd_waitreq_o),
    .addr_i(snd_addr_i),
    .cmd_i(cmd_ff),
    .ptr_i(ptr_ff),
    .stat_i(stat_word),
    .mask_i(mask_word),
    .take_o(snd_take),
    .rdata_o(snd_rdata_o)
  );

  // The receiver read port never stalls; its data follows one cycle on.
  omb_rd_port #(
    .DATA_W(DATA_W)
  ) u_rcv_rd (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .read_i(rcv_read_i),
    .hold_i(1'b0),
    .addr_i(rcv_addr_i),
    .cmd_i(cmd_ff),
    .ptr_i(ptr_ff),
    .stat_i(stat_word),
    .mask_i(mask_word),
    .take_o(rcv_take),
    .rdata_o(rcv_rdata_o)
  );

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  AST_CMD_WR_SETS_PEND: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    snd_cmd_wr |=> pend_ff && full_ff && snd_waitreq_o)
    else $error("Command write did not mark a message pending.");

  AST_CMD_RD_CONSUMES: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (rcv_take && (rcv_addr_i == OMB_CMD_OFS) && pend_ff)
      |=> !pend_ff && !full_ff && !irq_msg_o)
    else $error("Command read did not empty the mailbox.");

  AST_STALL_WHILE_PEND: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    pend_ff |-> snd_waitreq_o && !snd_wr_ok && !snd_take)
    else $error("Sender access accepted while a message is pending.");

  AST_IRQ_MSG_LEVEL: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (irq_msg_o && !rcv_consume && !rcv_mask_wr) |=> irq_msg_o)
    else $error("Pending interrupt dropped before retrieval.");

  AST_IRQ_FROM_STATUS: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    irq_msg_o == (ARRIVAL_IRQ_EN && stat_word[OMB_STAT_PEND_BIT]
      && mask_word[OMB_MASK_PEND_BIT]))
    else $error("Pending interrupt disagrees with status and mask.");

  AST_SET_BY_SENDER: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    !pend_ff ##1 pend_ff |-> $past(snd_cmd_wr))
    else $error("Pending bit set without a sender command write.");

  AST_CLR_BY_RECEIVER: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    $fell(full_ff) |-> $past(rcv_consume))
    else $error("Full bit cleared without a receiver command read.");

  AST_WORDS_HELD: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    pend_ff |=> $stable(cmd_ff) && $stable(ptr_ff))
    else $error("Stored message changed while pending.");

  AST_PTR_ALONE: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    snd_ptr_wr |=> !pend_ff && !snd_waitreq_o)
    else $error("Pointer write changed message state.");

  AST_PTR_NO_STALL: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (snd_write_i && !pend_ff && (snd_addr_i == OMB_PTR_OFS))
      |-> snd_ptr_wr)
    else $error("Pointer write stalled with an empty mailbox.");

  AST_RCV_STAT_RSVD: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (rcv_take && (rcv_addr_i == OMB_STAT_OFS))
      |=> (rcv_rdata_o[DATA_W-1:2] == '0)
        && (rcv_rdata_o[OMB_STAT_PEND_BIT] == $past(pend_ff)))
    else $error("Status read-back wrong or reserved bits set.");

  AST_SND_MASK_OWN: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    (snd_mask_wr && !rcv_mask_wr)
      |=> mask_ff[OMB_MASK_PEND_BIT] == $past(mask_ff[OMB_MASK_PEND_BIT]))
    else $error("Sender altered the pending mask bit.");

  AST_SPACE_IRQ: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    irq_space_o == (SPACE_IRQ_EN && !full_ff
      && mask_ff[OMB_MASK_SPACE_BIT]))
    else $error("Space interrupt disagrees with full bit and mask.");

  AST_MASK_OFF: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    !mask_ff[OMB_MASK_PEND_BIT] |-> !irq_msg_o)
    else $error("Pending interrupt raised while masked off.");

endmodule : omb_mailbox

// ---- logic/omb_pkg.sv ----
// Constants shared by the one-slot mailbox and its read-port helper.
// Assumes word addressing on both slave ports and a single system clock.
package omb_pkg;

  // ---------------------------------------------------------------------
  // Register map, word offsets
  // ---------------------------------------------------------------------
  localparam int OMB_ADDR_W = 2;
  localparam logic [OMB_ADDR_W-1:0] OMB_CMD_OFS = 2'h0;
  localparam logic [OMB_ADDR_W-1:0] OMB_PTR_OFS = 2'h1;
  localparam logic [OMB_ADDR_W-1:0] OMB_STAT_OFS = 2'h2;
  localparam logic [OMB_ADDR_W-1:0] OMB_MASK_OFS = 2'h3;

  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int OMB_STAT_PEND_BIT = 0;
  localparam int OMB_STAT_FULL_BIT = 1;
  localparam int OMB_MASK_PEND_BIT = 0;
  localparam int OMB_MASK_SPACE_BIT = 1;
  localparam logic OMB_STAT_RST = 1'h0;
  localparam logic [1:0] OMB_MASK_RST = 2'h0;
  localparam logic [31:0] OMB_WORD_RST = 32'h0000_0000;

  // ---------------------------------------------------------------------
  // Read timing: wait cycles between a taken read and its data
  // ---------------------------------------------------------------------
  localparam int OMB_READ_LATENCY_SETTING = 1;

  typedef enum logic {
    OMB_RD_IDLE,
    OMB_RD_WAIT
  } omb_rd_state_t;

endpackage : omb_pkg

// ---- logic/omb_rd_port.sv ----
// Read side of one mailbox slave port: one fixed wait cycle per taken read.
// Assumes the master holds read for two cycles and samples in the second.
`timescale 1ns/1ps
module omb_rd_port #(
  parameter int DATA_W = 32
)
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic read_i,
  input wire logic hold_i,
  input wire logic [omb_pkg::OMB_ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] cmd_i,
  input wire logic [DATA_W-1:0] ptr_i,
  input wire logic [DATA_W-1:0] stat_i,
  input wire logic [DATA_W-1:0] mask_i,
  output logic take_o,
  output logic [DATA_W-1:0] rdata_o
);
  import omb_pkg::*;

  omb_rd_state_t state_ff;

  // ---------------------------------------------------------------------
  // Read acceptance
  // ---------------------------------------------------------------------
  // Only the first unstalled cycle of a held read is taken, so a consuming read
  // of the command word acts exactly once.
  always_comb
  begin
    take_o = read_i && !hold_i && (state_ff == OMB_RD_IDLE);
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_ff <= OMB_RD_IDLE;
    end
    else
    begin
      case (state_ff)
        OMB_RD_IDLE:
        begin
          if (take_o)
          begin
            state_ff <= OMB_RD_WAIT;
          end
        end
        OMB_RD_WAIT: state_ff <= OMB_RD_IDLE;
        default: state_ff <= OMB_RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata_o <= '0;
    end
    else if (take_o)
    begin
      case (addr_i)
        OMB_CMD_OFS: rdata_o <= cmd_i;
        OMB_PTR_OFS: rdata_o <= ptr_i;
        OMB_STAT_OFS: rdata_o <= stat_i;
        OMB_MASK_OFS: rdata_o <= mask_i;
        default: rdata_o <= '0;
      endcase
    end
  end

  AST_RD_ONE_WAIT: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    take_o |=> (state_ff == OMB_RD_WAIT) ##1 (state_ff == OMB_RD_IDLE))
    else $error("Read wait phase did not last exactly one cycle.");

endmodule : omb_rd_port

// ---- verification/omb_proc_model.sv ----
// Behavioural sending and receiving processors for the one-slot mailbox.
// Assumes one caller per port at a time, each call starting after an edge.
`timescale 1ns/1ps
module omb_proc_model
(
  input wire logic clk_sys_i,
  input wire logic snd_waitreq_i,
  input wire logic [31:0] snd_rdata_i,
  input wire logic [31:0] rcv_rdata_i,
  output logic [omb_pkg::OMB_ADDR_W-1:0] snd_addr_o,
  output logic snd_read_o,
  output logic snd_write_o,
  output logic [31:0] snd_wdata_o,
  output logic [omb_pkg::OMB_ADDR_W-1:0] rcv_addr_o,
  output logic rcv_read_o,
  output logic rcv_write_o,
  output logic [31:0] rcv_wdata_o
);
  import omb_pkg::*;

  initial
  begin
    snd_addr_o = 2'h0;
    snd_read_o = 1'b0;
    snd_write_o = 1'b0;
    snd_wdata_o = 32'h0;
    rcv_addr_o = 2'h0;
    rcv_read_o = 1'b0;
    rcv_write_o = 1'b0;
    rcv_wdata_o = 32'h0;
  end

  // ---------------------------------------------------------------------
  // Port transfers
  // ---------------------------------------------------------------------
  // Released write data shows the inverse, so stale data never looks valid.
  task automatic snd_xfer(input logic wr, input logic [1:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    q = 32'h0;
    @(posedge clk_sys_i);
    #1;
    snd_addr_o = a;
    snd_write_o = wr;
    snd_read_o = !wr;
    snd_wdata_o = d;
    @(posedge clk_sys_i);
    while (snd_waitreq_i && n < 400)
    begin
      n++;
      @(posedge clk_sys_i);
    end
    if (!wr)
    begin
      @(posedge clk_sys_i);
      q = snd_rdata_i;
    end
    #1;
    snd_write_o = 1'b0;
    snd_read_o = 1'b0;
    snd_wdata_o = ~d;
  endtask : snd_xfer

  task automatic rcv_xfer(input logic wr, input logic [1:0] a,
    input logic [31:0] d, output logic [31:0] q);
    q = 32'h0;
    @(posedge clk_sys_i);
    #1;
    rcv_addr_o = a;
    rcv_write_o = wr;
    rcv_read_o = !wr;
    rcv_wdata_o = d;
    @(posedge clk_sys_i);
    if (!wr)
    begin
      @(posedge clk_sys_i);
      q = rcv_rdata_i;
    end
    #1;
    rcv_write_o = 1'b0;
    rcv_read_o = 1'b0;
    rcv_wdata_o = ~d;
  endtask : rcv_xfer

  // ---------------------------------------------------------------------
  // Message sequences
  // ---------------------------------------------------------------------
  task automatic send_msg(input logic use_ptr, input logic [31:0] p,
    input logic [31:0] c);
    logic [31:0] q;
    if (use_ptr)
      snd_xfer(1'b1, OMB_PTR_OFS, p, q);
    snd_xfer(1'b1, OMB_CMD_OFS, c, q);
  endtask : send_msg

  task automatic recv_msg(output logic [31:0] p, output logic [31:0] c);
    rcv_xfer(1'b0, OMB_PTR_OFS, 32'h0, p);
    rcv_xfer(1'b0, OMB_CMD_OFS, 32'h0, c);
  endtask : recv_msg

  task automatic poll(output logic [31:0] s);
    rcv_xfer(1'b0, OMB_STAT_OFS, 32'h0, s);
  endtask : poll
endmodule : omb_proc_model

// ---- verification/test_one_slot_message_mailbox.sv ----
// Self-checking bench for the one-slot mailbox with both processors modelled.
// Assumes the package, design and processor model are compiled first.
`timescale 1ns/1ps
module test_one_slot_message_mailbox;
  import omb_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [1:0] snd_addr;
  logic [1:0] rcv_addr;
  logic snd_read, snd_write, snd_waitreq, rcv_read, rcv_write;
  logic irq_msg, irq_space;
  logic [31:0] snd_wdata, snd_rdata, rcv_wdata, rcv_rdata, q, p, c;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  omb_mailbox #(.DATA_W(32), .ARRIVAL_IRQ_EN(1'b1), .SPACE_IRQ_EN(1'b1))
  dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .snd_addr_i(snd_addr), .snd_read_i(snd_read), .snd_write_i(snd_write),
    .snd_wdata_i(snd_wdata), .snd_rdata_o(snd_rdata),
    .snd_waitreq_o(snd_waitreq), .rcv_addr_i(rcv_addr),
    .rcv_read_i(rcv_read), .rcv_write_i(rcv_write),
    .rcv_wdata_i(rcv_wdata), .rcv_rdata_o(rcv_rdata),
    .irq_msg_o(irq_msg), .irq_space_o(irq_space));

  omb_proc_model partner_u (.clk_sys_i(clk_sys_i),
    .snd_waitreq_i(snd_waitreq), .snd_rdata_i(snd_rdata),
    .rcv_rdata_i(rcv_rdata), .snd_addr_o(snd_addr), .snd_read_o(snd_read),
    .snd_write_o(snd_write), .snd_wdata_o(snd_wdata), .rcv_addr_o(rcv_addr),
    .rcv_read_o(rcv_read), .rcv_write_o(rcv_write),
    .rcv_wdata_o(rcv_wdata));

  // ---------------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------------
  task automatic chk_w(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_w

  task automatic chk_b(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_b

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // The whole run needs little more than a hundred cycles, so this only cuts a hang.
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset;
    partner_u.poll(q);
    chk_w("status", 32'h0, q);
    partner_u.snd_xfer(1'b0, OMB_MASK_OFS, 32'h0, q);
    chk_w("mask", 32'h0, q);
    chk_b("irq_msg", 1'b0, irq_msg);
    chk_b("irq_space", 1'b0, irq_space);
    $display("test reset done");
  endtask : t_reset

  task automatic t_access;
    partner_u.rcv_xfer(1'b1, OMB_MASK_OFS, 32'hFFFF_FFFF, q);
    partner_u.rcv_xfer(1'b0, OMB_MASK_OFS, 32'h0, q);
    chk_w("rcv mask", 32'h1, q);
    partner_u.snd_xfer(1'b1, OMB_MASK_OFS, 32'hFFFF_FFFF, q);
    partner_u.snd_xfer(1'b0, OMB_MASK_OFS, 32'h0, q);
    chk_w("snd mask", 32'h3, q);
    chk_b("irq_space", 1'b1, irq_space);
    for (int i = 0; i < 3; i++)
      partner_u.rcv_xfer(1'b1, 2'(i), 32'hA5A5_A5A5, q);
    partner_u.snd_xfer(1'b1, OMB_STAT_OFS, 32'hFFFF_FFFF, q);
    partner_u.snd_xfer(1'b0, OMB_CMD_OFS, 32'h0, q);
    chk_w("cmd", 32'h0, q);
    partner_u.snd_xfer(1'b0, OMB_PTR_OFS, 32'h0, q);
    chk_w("ptr", OMB_WORD_RST, q);
    partner_u.poll(q);
    chk_w("status", 32'h0, q);
    chk_b("waitreq", 1'b0, snd_waitreq);
    $display("test access done");
  endtask : t_access

  task automatic t_flow;
    partner_u.send_msg(1'b1, 32'h1234_5678, 32'h0000_00C1);
    @(posedge clk_sys_i);
    #1;
    chk_b("waitreq", 1'b1, snd_waitreq);
    chk_b("irq_msg", 1'b1, irq_msg);
    chk_b("irq_space", 1'b0, irq_space);
    partner_u.poll(q);
    chk_w("status", 32'h3, q);
    repeat (4) @(posedge clk_sys_i);
    #1;
    chk_b("irq_msg", 1'b1, irq_msg);
    partner_u.recv_msg(p, c);
    chk_w("ptr", 32'h1234_5678, p);
    chk_w("cmd", 32'h0000_00C1, c);
    @(posedge clk_sys_i);
    #1;
    chk_b("waitreq", 1'b0, snd_waitreq);
    chk_b("irq_msg", 1'b0, irq_msg);
    chk_b("irq_space", 1'b1, irq_space);
    partner_u.poll(q);
    chk_w("status", 32'h0, q);
    $display("test flow done");
  endtask : t_flow

  task automatic t_stall;
    partner_u.rcv_xfer(1'b1, OMB_MASK_OFS, 32'h0, q);
    partner_u.send_msg(1'b0, 32'h0, 32'h0000_00A1);
    fork
      partner_u.snd_xfer(1'b1, OMB_CMD_OFS, 32'h0000_00B2, q);
      begin
        repeat (6) @(posedge clk_sys_i);
        #1;
        chk_b("waitreq", 1'b1, snd_waitreq);
        chk_b("irq_msg", 1'b0, irq_msg);
        partner_u.recv_msg(p, c);
        chk_w("cmd", 32'h0000_00A1, c);
      end
    join
    @(posedge clk_sys_i);
    #1;
    partner_u.poll(q);
    chk_w("status", 32'h3, q);
    partner_u.recv_msg(p, c);
    chk_w("ptr", 32'h1234_5678, p);
    chk_w("cmd", 32'h0000_00B2, c);
    $display("test stall done");
  endtask : t_stall

  // Reset lands while a message waits, so the stall and the read data
  // must drop at once, before any clock edge.
  task automatic t_midrst;
    partner_u.send_msg(1'b1, 32'h2468_ACE0, 32'h0000_00D4);
    @(posedge clk_sys_i);
    #1;
    chk_b("waitreq", 1'b1, snd_waitreq);
    reset_n_i = 1'b0;
    #1;
    chk_b("waitreq", 1'b0, snd_waitreq);
    chk_w("rcv_rdata", 32'h0, rcv_rdata);
    repeat (2) @(posedge clk_sys_i);
    #1;
    reset_n_i = 1'b1;
    partner_u.poll(q);
    chk_w("status", 32'h0, q);
    partner_u.snd_xfer(1'b0, OMB_CMD_OFS, 32'h0, q);
    chk_w("cmd", OMB_WORD_RST, q);
    partner_u.snd_xfer(1'b0, OMB_MASK_OFS, 32'h0, q);
    chk_w("mask", 32'h0, q);
    $display("test midrst done");
  endtask : t_midrst

  initial
  begin
    repeat (12) @(posedge clk_sys_i);
    #1;
    reset_n_i = 1'b1;
    t_reset();
    t_access();
    t_flow();
    t_stall();
    t_midrst();
    tally_and_finish();
  end
endmodule : test_one_slot_message_mailbox
